// ===== verilog/afe_pkg.sv
package afe_pkg;

   // -----------------------------------------------------------------
   // Register map (printed offsets are word indices; address = 4 * index)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_ERR_ENABLE  = 8'h06;
   localparam logic [7:0] IDX_SEQ_ENABLE  = 8'h07;
   localparam logic [7:0] IDX_ERR_FLAGS   = 8'h08;
   localparam logic [7:0] IDX_SEQ_FLAGS   = 8'h09;
   localparam logic [7:0] IDX_CTRL        = 8'h10;
   localparam logic [7:0] IDX_CONV_FLAGS  = 8'h11;
   localparam logic [7:0] IDX_STATUS      = 8'h12;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_TRIG_ERR  = 3;
   localparam int BIT_RSTR_ERR  = 2;
   localparam int BIT_LIST_LOAD_CONFIRM_ERR  = 1;
   localparam int BIT_ABORT_DN  = 7;
   localparam int BIT_CONV_OVR  = 6;
   localparam int BIT_CTL_EN    = 0;
   localparam int BIT_CTL_SRST  = 1;
   localparam int BIT_CTL_TRIGM = 2;
   localparam int BIT_CTL_STRSQ = 3;
   localparam int BIT_CTL_RVLDB = 4;
   localparam int BIT_CTL_CSLDB = 5;
   localparam int BIT_CTL_WAIT_MODE_HALT  = 6;

   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_CONV  = 16'h0000;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

   // Flow events from the sequencer, one-cycle pulses except the last_cmd level
   typedef struct packed {
      logic restart;         // restart event request
      logic restart_trig;    // hardware trigger generated by restart
      logic restart_loaded;  // restart finished loading first command
      logic trigger;         // trigger from data bus or internal interface
      logic seq_done;        // conversion sequence finished
      logic first_sample;    // first command of a sequence begins sampling
      logic eol_exec;        // end-of-list command executed
      logic eol_about;       // end-of-list command about to execute
      logic abort_req;       // sequence abort request
      logic abort_exec;      // sequence abort executed
      logic abort_hw_stop;   // abort generated by hardware for stop/wait
      logic last_cmd;        // last command of list executing (level)
      logic stop_exit;       // exit from stop mode
      logic first_store;     // first result of list stored
      logic [15:0] conv_set; // conversion flags 15..1 and end-of-list (bit 0)
   } afe_events_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_TRIG,
      ST_RUN
   } afe_state_type;

endpackage : afe_pkg

// ===== verilog/afe_flow_flags.sv
// How it works
// - restart mode: trigger after abort sets error
// - trigger mode: trigger before first restart errs
// - trigger before sequence end sets error
// - trigger during first-sample processing sets error
// - trigger mode: restart trigger plus external trigger errs
// - trigger error halts converter operation
// - restart after trigger before list end errs
// - restart request overrun never flags restart error
// - restart mode restart without load-confirm errs
// - no load error during or with abort
// - first restart and single buffer suppress
// - write one clears, except the sticky trigger error; zero and set ignored
// - disabled converter holds all flags clear
// - executed abort sets done, except hardware
// - no done for abort at list end
// - overrun of conversion flags sets overrun
// - double buffer: flag still set overruns
// - single buffer: check at first store
// - restart and load errors clear by one
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module afe_flow_flags
   import afe_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                 I_CLK,
   input  wire logic                 I_SRST,
   input  wire logic                 I_CE,
   // APB slave
   input  wire logic                 I_PSEL,
   input  wire logic                 I_PENABLE,
   input  wire logic                 I_PWRITE,
   input  wire logic [11:0]          I_PADDR,
   input  wire logic [31:0]          I_PWDATA,
   output logic      [31:0]          O_PRDATA,
   output logic                      O_PREADY,
   output logic                      O_PSLVERR,
   // Sequencer events
   input  wire afe_pkg::afe_events_type I_EVT,
   input  wire logic                 I_LIST_LOAD_CONFIRM,
   // Status
   output logic                      O_HALT,
   output logic                      O_IRQ
);
   import afe_pkg::*;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic [7:0]  err_flags;
   logic [7:0]  seq_flags;
   logic [7:0]  err_en;
   logic [7:0]  seq_en;
   logic [6:0]  ctrl;
   logic [15:0] conv_flags;
   logic [15:0] next_conv_flags;
   afe_state_type state;
   logic        first_restart;
   logic        abort_in_progress;
   logic        trig_pending;
   logic        restart_busy;
   logic        list_active;
   logic        conv_ovr_evt;

   function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
      hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
   endfunction : hit

   wire logic acc   = I_PSEL && I_PENABLE && !O_PREADY;
   // Writes land at the edge that completes the transfer, with ready high
   wire logic wr    = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
   wire logic [7:0] wb = I_PWDATA[7:0];
   wire logic conv_en     = ctrl[BIT_CTL_EN];
   wire logic soft_rst    = wr && hit(I_PADDR, IDX_CTRL) && I_PWDATA[BIT_CTL_SRST];
   wire logic trig_mode   = ctrl[BIT_CTL_TRIGM];
   wire logic clr_all     = !conv_en || soft_rst;
   wire logic live        = conv_en && !err_flags[BIT_TRIG_ERR];
   wire logic w_err  = wr && hit(I_PADDR, IDX_ERR_FLAGS);
   wire logic w_seq  = wr && hit(I_PADDR, IDX_SEQ_FLAGS);
   wire logic w_conv = wr && hit(I_PADDR, IDX_CONV_FLAGS);
   wire logic mapped = hit(I_PADDR, IDX_ERR_ENABLE) || hit(I_PADDR, IDX_SEQ_ENABLE)
                    || hit(I_PADDR, IDX_ERR_FLAGS) || hit(I_PADDR, IDX_SEQ_FLAGS)
                    || hit(I_PADDR, IDX_CTRL) || hit(I_PADDR, IDX_CONV_FLAGS)
                    || hit(I_PADDR, IDX_STATUS);

   // ----------------------------------------------------------------
   // APB answer: one wait state, ready from a flop
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= RD_ZERO;
      end
      else if (I_CE)
      begin
         O_PREADY  <= acc;
         O_PSLVERR <= acc && !mapped;
         if (acc && !I_PWRITE)
         begin
            O_PRDATA <= RD_ZERO;
            if (hit(I_PADDR, IDX_ERR_ENABLE)) O_PRDATA[7:0] <= err_en;
            if (hit(I_PADDR, IDX_SEQ_ENABLE)) O_PRDATA[7:0] <= seq_en;
            if (hit(I_PADDR, IDX_ERR_FLAGS))  O_PRDATA[7:0] <= err_flags;
            if (hit(I_PADDR, IDX_SEQ_FLAGS))  O_PRDATA[7:0] <= seq_flags;
            if (hit(I_PADDR, IDX_CTRL))       O_PRDATA[6:0] <= ctrl;
            if (hit(I_PADDR, IDX_CONV_FLAGS)) O_PRDATA[15:0] <= conv_flags;
            if (hit(I_PADDR, IDX_STATUS))     O_PRDATA[1:0] <= {abort_in_progress, O_HALT};
         end
      end
   end

   // ----------------------------------------------------------------
   // Control and enable registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         ctrl   <= 7'h00;
         err_en <= RST_BYTE;
         seq_en <= RST_BYTE;
      end
      else if (I_CE && wr)
      begin
         // Soft reset bit is self-clearing and never stored
         if (hit(I_PADDR, IDX_CTRL))       ctrl   <= I_PWDATA[6:0] & 7'h7d;
         if (hit(I_PADDR, IDX_ERR_ENABLE)) err_en <= wb & 8'h0e;
         if (hit(I_PADDR, IDX_SEQ_ENABLE)) seq_en <= wb & 8'hc0;
      end
   end

   // ----------------------------------------------------------------
   // Flow tracking
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         state             <= ST_IDLE;
         first_restart     <= 1'b1;
         abort_in_progress <= 1'b0;
         trig_pending      <= 1'b0;
         restart_busy      <= 1'b0;
         list_active       <= 1'b0;
      end
      else if (I_CE)
      begin
         if (clr_all || I_EVT.stop_exit)
         begin
            state             <= ST_IDLE;
            first_restart     <= 1'b1;
            abort_in_progress <= 1'b0;
            trig_pending      <= 1'b0;
            restart_busy      <= 1'b0;
            list_active       <= 1'b0;
         end
         else if (live)
         begin
            if (I_EVT.restart)
               first_restart <= 1'b0;
            if (I_EVT.abort_req)
               abort_in_progress <= 1'b1;
            else if (I_EVT.abort_exec)
               abort_in_progress <= 1'b0;
            if (I_EVT.trigger || I_EVT.restart_trig)
               trig_pending <= 1'b1;
            else if (I_EVT.first_sample)
               trig_pending <= 1'b0;
            if (I_EVT.restart)
               restart_busy <= 1'b1;
            else if (I_EVT.restart_loaded)
               restart_busy <= 1'b0;
            if (I_EVT.trigger || I_EVT.restart_trig)
               list_active <= 1'b1;
            else if (I_EVT.eol_exec || I_EVT.abort_exec
                     || (I_EVT.eol_about && ctrl[BIT_CTL_STRSQ]))
               list_active <= 1'b0;
            // An executed abort forgets the list: a restart is needed again
            if (I_EVT.abort_exec)
               state <= ST_IDLE;
            else
               case (state)
                  // A restart-made trigger starts the sequence at once
                  ST_IDLE:
                     if (I_EVT.restart_trig) state <= ST_RUN;
                     else if (I_EVT.restart) state <= ST_WAIT_TRIG;
                  ST_WAIT_TRIG: if (I_EVT.trigger || I_EVT.restart_trig) state <= ST_RUN;
                  ST_RUN:       if (I_EVT.seq_done) state <= ST_WAIT_TRIG;
                  default:      state <= ST_IDLE;
               endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Error flags
   // ----------------------------------------------------------------
   wire logic trig_err_evt =
        live && I_EVT.trigger && (
        (!trig_mode && (state == ST_IDLE || restart_busy))
     || (trig_mode && state == ST_IDLE)
     || (state == ST_RUN)
     || trig_pending
     || (trig_mode && I_EVT.restart_trig));

   // Second restart while one is still loading is an overrun, not an error
   wire logic rstr_err_evt = live && I_EVT.restart && list_active
                          && !abort_in_progress && !I_EVT.abort_req
                          && !restart_busy;

   wire logic list_load_confirm_err_evt = live && !trig_mode && I_EVT.restart
                          && !I_LIST_LOAD_CONFIRM
                          && !abort_in_progress && !I_EVT.abort_req
                          && !first_restart && ctrl[BIT_CTL_CSLDB];

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         err_flags <= RST_BYTE;
      else if (I_CE)
      begin
         if (clr_all)
            err_flags <= RST_BYTE;
         else
         begin
            // Set wins over a simultaneous write-one clear
            err_flags[BIT_TRIG_ERR] <= err_flags[BIT_TRIG_ERR] || trig_err_evt;
            err_flags[BIT_RSTR_ERR] <= rstr_err_evt
               || (err_flags[BIT_RSTR_ERR] && !(w_err && wb[BIT_RSTR_ERR]));
            err_flags[BIT_LIST_LOAD_CONFIRM_ERR] <= list_load_confirm_err_evt
               || (err_flags[BIT_LIST_LOAD_CONFIRM_ERR] && !(w_err && wb[BIT_LIST_LOAD_CONFIRM_ERR]));
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequence flags and conversion flags
   // ----------------------------------------------------------------
   wire logic abort_done_evt = live && I_EVT.abort_exec
        && !(I_EVT.abort_hw_stop)
        && !(I_EVT.last_cmd && ctrl[BIT_CTL_STRSQ]);

   assign conv_ovr_evt = live && (ctrl[BIT_CTL_RVLDB]
        ? |(conv_flags & I_EVT.conv_set)
        : (I_EVT.first_store && |conv_flags[15:1]));

   always_comb
   begin
      next_conv_flags = conv_flags;
      if (w_conv)
         next_conv_flags = conv_flags & ~I_PWDATA[15:0];
      if (live)
         next_conv_flags = next_conv_flags | I_EVT.conv_set;
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         seq_flags  <= RST_BYTE;
         conv_flags <= RST_CONV;
      end
      else if (I_CE)
      begin
         if (clr_all)
         begin
            seq_flags  <= RST_BYTE;
            conv_flags <= RST_CONV;
         end
         else
         begin
            seq_flags[BIT_ABORT_DN] <= abort_done_evt
               || (seq_flags[BIT_ABORT_DN] && !(w_seq && wb[BIT_ABORT_DN]));
            seq_flags[BIT_CONV_OVR] <= conv_ovr_evt
               || (seq_flags[BIT_CONV_OVR] && !(w_seq && wb[BIT_CONV_OVR]));
            conv_flags <= next_conv_flags;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_HALT <= 1'b0;
         O_IRQ  <= 1'b0;
      end
      else if (I_CE)
      begin
         O_HALT <= err_flags[BIT_TRIG_ERR];
         O_IRQ  <= |(err_flags & err_en) || |(seq_flags & seq_en);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_TRIG_STICKY: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && err_flags[BIT_TRIG_ERR] && conv_en && !soft_rst
      |=> err_flags[BIT_TRIG_ERR])
      else $error("trigger error flag lost without soft reset");
   AST_HALT_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && err_flags[BIT_TRIG_ERR] |=> O_HALT)
      else $error("halt not raised after trigger error");
   AST_DISABLED_CLEAR: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && !conv_en |=> err_flags == RST_BYTE && seq_flags == RST_BYTE)
      else $error("flags not cleared while disabled");
   AST_RUN_TRIG: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && live && I_EVT.trigger && state == ST_RUN && !soft_rst
      |=> err_flags[BIT_TRIG_ERR])
      else $error("trigger during sequence not flagged");
   AST_LIST_LOAD_CONFIRM_MODE: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && trig_mode && !err_flags[BIT_LIST_LOAD_CONFIRM_ERR] && !soft_rst |=> !err_flags[BIT_LIST_LOAD_CONFIRM_ERR])
      else $error("load error set in trigger mode");
   AST_LIST_LOAD_CONFIRM_ABORT: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && I_EVT.abort_req && !err_flags[BIT_LIST_LOAD_CONFIRM_ERR] |=> !err_flags[BIT_LIST_LOAD_CONFIRM_ERR])
      else $error("load error set with abort request");
   AST_SET_WINS: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && !clr_all && abort_done_evt |=> seq_flags[BIT_ABORT_DN])
      else $error("abort done event lost");
   AST_NO_DONE_LAST: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && I_EVT.last_cmd && ctrl[BIT_CTL_STRSQ] && !seq_flags[BIT_ABORT_DN]
      |=> !seq_flags[BIT_ABORT_DN])
      else $error("abort done set at list end");
   AST_IRQ: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && (err_flags & err_en) != RST_BYTE |=> O_IRQ)
      else $error("interrupt not raised");
   AST_RSTR_OVR: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && restart_busy && !err_flags[BIT_RSTR_ERR] && !I_EVT.abort_exec
      |=> !err_flags[BIT_RSTR_ERR])
      else $error("restart overrun flagged");
   AST_TRIG_EARLY: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && live && trig_mode && I_EVT.trigger && state == ST_IDLE && !soft_rst
      |=> err_flags[BIT_TRIG_ERR])
      else $error("trigger before first restart not flagged");
   AST_TRIG_ABORTED: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && live && !trig_mode && I_EVT.trigger && !soft_rst
      && (state == ST_IDLE || restart_busy) |=> err_flags[BIT_TRIG_ERR])
      else $error("trigger without finished restart not flagged");
   AST_TRIG_DOUBLE: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && live && trig_mode && I_EVT.trigger && I_EVT.restart_trig && !soft_rst
      |=> err_flags[BIT_TRIG_ERR])
      else $error("coincident triggers not flagged");
   AST_RSTR_SET: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && live && I_EVT.restart && list_active && !restart_busy && !soft_rst
      && !abort_in_progress && !I_EVT.abort_req |=> err_flags[BIT_RSTR_ERR])
      else $error("restart during list not flagged");
   AST_LIST_LOAD_CONFIRM_FIRST: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && (first_restart || !ctrl[BIT_CTL_CSLDB]) && !err_flags[BIT_LIST_LOAD_CONFIRM_ERR]
      |=> !err_flags[BIT_LIST_LOAD_CONFIRM_ERR])
      else $error("load error not suppressed");
   AST_DONE_HW: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && I_EVT.abort_hw_stop && !seq_flags[BIT_ABORT_DN]
      |=> !seq_flags[BIT_ABORT_DN])
      else $error("abort done set for hardware abort");
   AST_OVR_DOUBLE: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && live && ctrl[BIT_CTL_RVLDB] && |(conv_flags & I_EVT.conv_set) && !soft_rst
      |=> seq_flags[BIT_CONV_OVR])
      else $error("double buffer overrun not flagged");
   AST_OVR_SINGLE: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && !ctrl[BIT_CTL_RVLDB] && !I_EVT.first_store && !seq_flags[BIT_CONV_OVR]
      |=> !seq_flags[BIT_CONV_OVR])
      else $error("single buffer overrun outside first store");
   AST_NO_SET_BY_WRITE: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_CE && w_err && !rstr_err_evt && !err_flags[BIT_RSTR_ERR]
      |=> !err_flags[BIT_RSTR_ERR])
      else $error("write set a restart error flag");

endmodule : afe_flow_flags
`default_nettype wire

// ===== dv/afe_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
module afe_evt_src
   import afe_pkg::*;
(
   // Clock
   input  wire logic              i_clk,
   // Requests from software and trigger sources
   input  wire afe_pkg::afe_events_type i_req,
   // Event pulses toward the flag logic
   output var  afe_pkg::afe_events_type o_evt
);
   // Registered so every event leaves just after an edge, never mid-cycle
   always_ff @(posedge i_clk)
   begin
      o_evt <= i_req;
   end
endmodule : afe_evt_src
`default_nettype wire

// ===== dv/tb_afe_flow_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_afe_flow_flags;
   import afe_pkg::*;
   // ----------------------------------------------------------------
   // Event masks, one bit per single-bit field of the event struct except eol_about
   // ----------------------------------------------------------------
   localparam logic [29:0] Z   = 30'h0;
   localparam logic [29:0] RST = 30'h2000_0000;
   localparam logic [29:0] RTG = 30'h1000_0000;
   localparam logic [29:0] LDD = 30'h0800_0000;
   localparam logic [29:0] TRG = 30'h0400_0000;
   localparam logic [29:0] FS  = 30'h0100_0000;
   localparam logic [29:0] ABR = 30'h0020_0000;
   localparam logic [29:0] ABX = 30'h0010_0000;
   localparam logic [29:0] AHW = 30'h0008_0000;
   localparam logic [29:0] LC  = 30'h0004_0000;
   localparam logic [29:0] FST = 30'h0001_0000;
   localparam logic [29:0] SD  = 30'h0200_0000;
   localparam logic [29:0] EOX = 30'h0080_0000;
   localparam logic [29:0] SX  = 30'h0002_0000;
   localparam int          NC  = 14;

   logic                 clk;
   logic                 srst;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic                 list_load_confirm;
   logic                 pready;
   logic                 pslverr;
   logic                 halt;
   logic                 irq;
   logic                 se;
   logic [11:0]          paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic [31:0]          rd;
   afe_events_type       req;
   afe_events_type       evt;
   int                   err_total   = 0;
   int                   checks_done = 0;
   int                   cyc         = 0;

   // Flow cases: control byte, event steps, expected error flags
   logic [7:0]  tctl [NC] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h01, 8'h01, 8'h01,
                              8'h21, 8'h21, 8'h21, 8'h21, 8'h05, 8'h05, 8'h21};
   logic [7:0]  texp [NC] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h04,
                              8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02};
   logic [29:0] tseq [NC][4] = '{'{TRG, Z, Z, Z}, '{RST | RTG | TRG, Z, Z, Z},
      '{RST | RTG, LDD, FS, TRG}, '{RST | RTG, LDD, FS | TRG, Z}, '{RST, LDD, ABX, TRG},
      '{RST, TRG, Z, Z}, '{RST, LDD, TRG, RST}, '{RST, LDD, RST | ABR, Z},
      '{RST, LDD, ABR, RST}, '{RST, Z, Z, Z}, '{RST, LDD, SX, RST},
      '{RST | RTG, FS, SD, RST | RTG | TRG}, '{RST | RTG, LDD, EOX, RST},
      '{RST, LDD, RST, Z}};

   afe_evt_src src (.i_clk(clk), .i_req(req), .o_evt(evt));

   afe_flow_flags dut (.I_CLK(clk), .I_SRST(srst), .I_CE(1'b1), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVT(evt),
      .I_LIST_LOAD_CONFIRM(list_load_confirm), .O_HALT(halt), .O_IRQ(irq));

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for ready
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h0, d});
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, RD_ZERO);
      chk(rd, exp);
   endtask : rdc

   // The last-command bit is a level, so it outlives the one-cycle pulse
   task automatic ev(input logic [29:0] m);
      @(posedge clk);
      req <= afe_events_type'(m);
      @(posedge clk);
      req <= afe_events_type'(m & LC);
   endtask : ev

   // ----------------------------------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_total++;
         report_and_stop;
      end
   end

   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = RD_ZERO;
      list_load_confirm = 1'b0;
      req = afe_events_type'(Z);
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rdc(IDX_ERR_FLAGS, RD_ZERO);
      rdc(IDX_SEQ_FLAGS, RD_ZERO);
      apb(1'b0, 8'h3f, RD_ZERO);
      chk(rd, RD_ZERO);
      chk({31'h0, se}, 32'h1);
      wr(IDX_ERR_ENABLE, 8'h08);
      for (int i = 0; i < NC; i++)
      begin
         wr(IDX_CTRL, tctl[i] | 8'h02);
         for (int j = 0; j < 4; j++)
            if (tseq[i][j] != Z)
               ev(tseq[i][j]);
         rdc(IDX_ERR_FLAGS, {24'h0, texp[i]});
         chk({31'h0, halt}, {31'h0, texp[i][3]});
         chk({31'h0, irq}, {31'h0, texp[i][3]});
         if (i == 0)
         begin
            wr(IDX_ERR_FLAGS, 8'h08);
            rdc(IDX_ERR_FLAGS, 32'h8);
         end
      end
      wr(IDX_ERR_FLAGS, 8'h00);
      rdc(IDX_ERR_FLAGS, 32'h2);
      wr(IDX_ERR_FLAGS, 8'h02);
      rdc(IDX_ERR_FLAGS, RD_ZERO);
      list_load_confirm <= 1'b1;
      ev(LDD);
      ev(RST);
      rdc(IDX_ERR_FLAGS, RD_ZERO);
      wr(IDX_CTRL, 8'h03);
      wr(IDX_SEQ_ENABLE, 8'h80);
      ev(ABX);
      rdc(IDX_SEQ_FLAGS, 32'h80);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_SEQ_FLAGS, 8'h80);
      rdc(IDX_SEQ_FLAGS, RD_ZERO);
      ev(ABX | AHW);
      rdc(IDX_SEQ_FLAGS, RD_ZERO);
      wr(IDX_CTRL, 8'h0b);
      ev(ABR | LC);
      rdc(IDX_STATUS, 32'h2);
      ev(ABX | LC);
      rdc(IDX_SEQ_FLAGS, RD_ZERO);
      wr(IDX_CTRL, 8'h13);
      ev(30'h8);
      ev(30'h8);
      rdc(IDX_SEQ_FLAGS, 32'h40);
      wr(IDX_CTRL, 8'h03);
      ev(30'h1);
      ev(30'h1);
      rdc(IDX_SEQ_FLAGS, RD_ZERO);
      ev(30'h4);
      ev(FST);
      rdc(IDX_SEQ_FLAGS, 32'h40);
      wr(IDX_CTRL, 8'h00);
      rdc(IDX_SEQ_FLAGS, RD_ZERO);
      rdc(IDX_CONV_FLAGS, RD_ZERO);
      report_and_stop;
   end
endmodule : tb_afe_flow_flags
`default_nettype wire
